// ===== inc/pio_cfg.svh
// constants for the parallel i/o block
// assumes a single synchronous processor-side register interface
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH
`define PIO_PORT_W 8
`define PIO_ADDR_W 3
`define PIO_SEL_DATA_A 3'h0
`define PIO_SEL_DATA_B 3'h1
`define PIO_SEL_DATA_C 3'h2
`define PIO_SEL_DATA_D 3'h3
`define PIO_SEL_DIR_A 3'h4
`define PIO_SEL_DIR_B 3'h5
`define PIO_SEL_DIR_C 3'h6
`define PIO_SEL_NONE 3'h7
`define PIO_FIX_IN_RST 5'h1f
`define PIO_DIR_RST 8'h00
`define PIO_LATCH_RST 8'h00
`define PIO_FIXED_MASK 8'hbf
`define PIO_SER_BITS 8'h03
`define PIO_SPI_BITS 8'h3c
`define PIO_BIT_RXD 0
`define PIO_BIT_TXD 1
`define PIO_BIT_MISO 2
`define PIO_BIT_MOSI 3
`define PIO_BIT_SCK 4
`define PIO_BIT_SS 5
`endif

// ===== inc/pio_pkg.sv
// types shared by the parallel i/o block
// assumes pio_cfg.svh is on the include path
`default_nettype none
package pio_pkg;
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pin_drive_t;
   typedef struct packed {
      logic rx_en;
      logic tx_en;
      logic spi_en;
   } serial_ctl_t;
endpackage
`default_nettype wire

// ===== rtl/parallel_io_ports.sv
// parallel i/o: three bidirectional ports and one fixed input port
// assumes pin inputs synchronous to clk_sys; processor access is a one-cycle strobe
// Operation
// - each bidirectional port has an 8-bit direction register, one bit per pin
// - direction one drives pin from latch; a write updates latch and pin
// - direction zero leaves pin undriven, but writes still load the latch
// - reading an input-direction bit returns the pin level
// - reading an output-direction bit returns the latch value
// - reset clears all direction registers, making every pin an input
// - direction registers are writable and read back the last value
// - fixed port has seven input bits 0-5 and 7, no data register
// - with serial functions off, fixed port reads give pin levels at read
// - reset disables all special-function drivers on the fixed port
// - serial receiver and transmitter both enabled make fixed bits 0,1 read zero
// - with spi disabled, fixed bits 2-5 read the pin states
// - serial unit uses fixed bit 0 as receive input, bit 1 as transmit
// - spi uses fixed bits 2-5 as miso, mosi, sck, ss
`include "pio_cfg.svh"
`default_nettype none
module parallel_io_ports #(
   parameter int PORT_W = `PIO_PORT_W
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [`PIO_ADDR_W-1:0] cpu_addr,
   input wire logic [PORT_W-1:0] cpu_wdata,
   output var logic [PORT_W-1:0] cpu_rdata,
   input wire logic [PORT_W-1:0] first_bidir_port_pins_i,
   output var logic [PORT_W-1:0] first_bidir_port_pins_o,
   output var logic [PORT_W-1:0] first_bidir_port_pins_oe,
   input wire logic [PORT_W-1:0] second_bidir_port_pins_i,
   output var logic [PORT_W-1:0] second_bidir_port_pins_o,
   output var logic [PORT_W-1:0] second_bidir_port_pins_oe,
   input wire logic [PORT_W-1:0] third_bidir_port_pins_i,
   output var logic [PORT_W-1:0] third_bidir_port_pins_o,
   output var logic [PORT_W-1:0] third_bidir_port_pins_oe,
   input wire logic [PORT_W-1:0] input_only_port_pins,
   input wire pio_pkg::serial_ctl_t serial_ctl,
   input wire logic serial_tx_data,
   input wire logic spi_miso_out,
   input wire logic spi_miso_oe,
   input wire logic spi_mosi_out,
   input wire logic spi_mosi_oe,
   input wire logic spi_sck_out,
   input wire logic spi_sck_oe,
   output var logic serial_receive_input,
   output var logic spi_miso_in,
   output var logic spi_mosi_in,
   output var logic spi_sck_in,
   output var logic spi_ss_n_in,
   output var pio_pkg::pin_drive_t fixed_drive
);
   import pio_pkg::*;

   logic [PORT_W-1:0] dir_r [3];
   logic [PORT_W-1:0] dir_nxt [3];
   logic [PORT_W-1:0] latch_r [3];
   logic [PORT_W-1:0] latch_nxt [3];
   logic [PORT_W-1:0] pin_in [3];
   logic [PORT_W-1:0] rdata_nxt;
   pin_drive_t fixed_nxt;
   logic [4:0] fix_in_nxt;
   logic [4:0] fix_in_r;

   // mixes pin and latch per direction bit
   function automatic logic [PORT_W-1:0] port_view(input logic [PORT_W-1:0] dir,
      input logic [PORT_W-1:0] lat, input logic [PORT_W-1:0] pin);
      port_view = (dir & lat) | (~dir & pin);
   endfunction

   assign pin_in[0] = first_bidir_port_pins_i;
   assign pin_in[1] = second_bidir_port_pins_i;
   assign pin_in[2] = third_bidir_port_pins_i;

   always_comb begin
      for (int p = 0; p < 3; p++) begin
         dir_nxt[p] = dir_r[p];
         latch_nxt[p] = latch_r[p];
      end
      if (cpu_wr) begin
         unique case (cpu_addr)
            `PIO_SEL_DATA_A: latch_nxt[0] = cpu_wdata;
            `PIO_SEL_DATA_B: latch_nxt[1] = cpu_wdata;
            `PIO_SEL_DATA_C: latch_nxt[2] = cpu_wdata;
            `PIO_SEL_DIR_A: dir_nxt[0] = cpu_wdata;
            `PIO_SEL_DIR_B: dir_nxt[1] = cpu_wdata;
            `PIO_SEL_DIR_C: dir_nxt[2] = cpu_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         for (int p = 0; p < 3; p++) begin
            dir_r[p] <= `PIO_DIR_RST;
            latch_r[p] <= `PIO_LATCH_RST;
         end
      end else begin
         for (int p = 0; p < 3; p++) begin
            dir_r[p] <= dir_nxt[p];
            latch_r[p] <= latch_nxt[p];
         end
      end
   end

   // direction and latch registers
   AST_DIR_B_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_wr && cpu_addr == `PIO_SEL_DIR_B |=> second_bidir_port_pins_oe == $past(cpu_wdata))
      else $error("port b direction write lost");
   AST_DIR_C_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_wr && cpu_addr == `PIO_SEL_DIR_C |=> third_bidir_port_pins_oe == $past(cpu_wdata))
      else $error("port c direction write lost");
   AST_LATCH_A_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_wr && cpu_addr == `PIO_SEL_DATA_A |=> first_bidir_port_pins_o == $past(cpu_wdata))
      else $error("port a latch write lost");
   AST_LATCH_C_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_wr && cpu_addr == `PIO_SEL_DATA_C |=> third_bidir_port_pins_o == $past(cpu_wdata))
      else $error("port c latch write lost");
   AST_DIR_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !cpu_wr |=> $stable(first_bidir_port_pins_oe) && $stable(second_bidir_port_pins_oe)
      && $stable(third_bidir_port_pins_oe))
      else $error("direction changed without a write");
   AST_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !cpu_wr |=> $stable(first_bidir_port_pins_o) && $stable(second_bidir_port_pins_o)
      && $stable(third_bidir_port_pins_o))
      else $error("latch changed without a write");
   AST_DATA_WR_KEEPS_DIR: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_wr && cpu_addr == `PIO_SEL_DATA_A |=> $stable(first_bidir_port_pins_oe))
      else $error("data write disturbed direction");
   AST_REFUSED_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_wr && (cpu_addr == `PIO_SEL_DATA_D || cpu_addr == `PIO_SEL_NONE)
      |=> $stable(first_bidir_port_pins_o) && $stable(first_bidir_port_pins_oe))
      else $error("ignored address changed a register");

   // pin drive straight from registers, no extra stage
   always_comb begin
      first_bidir_port_pins_o = latch_r[0];
      first_bidir_port_pins_oe = dir_r[0];
      second_bidir_port_pins_o = latch_r[1];
      second_bidir_port_pins_oe = dir_r[1];
      third_bidir_port_pins_o = latch_r[2];
      third_bidir_port_pins_oe = dir_r[2];
   end

   // fixed port: special-function drivers and input routing
   always_comb begin
      fixed_nxt = '0;
      if (serial_ctl.tx_en) begin
         fixed_nxt.out[`PIO_BIT_TXD] = serial_tx_data;
         fixed_nxt.oe[`PIO_BIT_TXD] = 1'b1;
      end
      if (serial_ctl.spi_en) begin
         fixed_nxt.out[`PIO_BIT_MISO] = spi_miso_out;
         fixed_nxt.oe[`PIO_BIT_MISO] = spi_miso_oe;
         fixed_nxt.out[`PIO_BIT_MOSI] = spi_mosi_out;
         fixed_nxt.oe[`PIO_BIT_MOSI] = spi_mosi_oe;
         fixed_nxt.out[`PIO_BIT_SCK] = spi_sck_out;
         fixed_nxt.oe[`PIO_BIT_SCK] = spi_sck_oe;
      end
      fix_in_nxt = {input_only_port_pins[`PIO_BIT_SS], input_only_port_pins[`PIO_BIT_SCK],
         input_only_port_pins[`PIO_BIT_MOSI], input_only_port_pins[`PIO_BIT_MISO],
         input_only_port_pins[`PIO_BIT_RXD]};
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         fixed_drive <= '0;
         fix_in_r <= `PIO_FIX_IN_RST;
      end else begin
         fixed_drive <= fixed_nxt;
         fix_in_r <= fix_in_nxt;
      end
   end

   // fixed port drive and input copies
   AST_TX_DRIVE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      serial_ctl.tx_en |=> fixed_drive.oe[`PIO_BIT_TXD]
      && fixed_drive.out[`PIO_BIT_TXD] == $past(serial_tx_data))
      else $error("transmit pin not driven");
   AST_TX_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !serial_ctl.tx_en |=> !fixed_drive.oe[`PIO_BIT_TXD])
      else $error("transmit pin driven while transmitter off");
   AST_RX_UNDRIVEN: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !fixed_drive.oe[`PIO_BIT_RXD])
      else $error("receive pin driven");
   AST_UPPER_UNDRIVEN: assert property (@(posedge clk_sys) disable iff (!arst_n)
      fixed_drive.oe[`PIO_PORT_W-1:`PIO_BIT_SS] == '0)
      else $error("select or upper fixed pins driven");
   AST_SPI_DRIVE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      serial_ctl.spi_en |=> fixed_drive.oe[`PIO_BIT_SCK:`PIO_BIT_MISO]
      == $past({spi_sck_oe, spi_mosi_oe, spi_miso_oe}))
      else $error("spi enables not routed");
   AST_SPI_OUT: assert property (@(posedge clk_sys) disable iff (!arst_n)
      serial_ctl.spi_en |=> fixed_drive.out[`PIO_BIT_SCK:`PIO_BIT_MISO]
      == $past({spi_sck_out, spi_mosi_out, spi_miso_out}))
      else $error("spi outputs not routed");
   AST_SPI_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !serial_ctl.spi_en |=> fixed_drive.oe[`PIO_BIT_SCK:`PIO_BIT_MISO] == 3'h0)
      else $error("spi pins driven while spi off");
   AST_RESET_DRIVE: assert property (@(posedge clk_sys)
      $rose(arst_n) |-> fixed_drive.oe == '0)
      else $error("fixed port driven out of reset");
   AST_RX_ROUTE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      1'b1 |=> serial_receive_input == $past(input_only_port_pins[`PIO_BIT_RXD]))
      else $error("receive input not copied from pin");
   AST_SPI_ROUTE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      1'b1 |=> {spi_ss_n_in, spi_sck_in, spi_mosi_in, spi_miso_in}
      == $past(input_only_port_pins[`PIO_BIT_SS:`PIO_BIT_MISO]))
      else $error("spi inputs not copied from pins");

   always_comb begin
      serial_receive_input = fix_in_r[0];
      spi_miso_in = fix_in_r[1];
      spi_mosi_in = fix_in_r[2];
      spi_sck_in = fix_in_r[3];
      spi_ss_n_in = fix_in_r[4];
   end

   // read data registered one cycle after the read strobe
   always_comb begin
      rdata_nxt = '0;
      if (cpu_rd) begin
         unique case (cpu_addr)
            `PIO_SEL_DATA_A: rdata_nxt = port_view(dir_r[0], latch_r[0], pin_in[0]);
            `PIO_SEL_DATA_B: rdata_nxt = port_view(dir_r[1], latch_r[1], pin_in[1]);
            `PIO_SEL_DATA_C: rdata_nxt = port_view(dir_r[2], latch_r[2], pin_in[2]);
            `PIO_SEL_DATA_D: begin
               rdata_nxt = input_only_port_pins & `PIO_FIXED_MASK;
               if (serial_ctl.rx_en && serial_ctl.tx_en)
                  rdata_nxt = rdata_nxt & ~`PIO_SER_BITS;
            end
            `PIO_SEL_DIR_A: rdata_nxt = dir_r[0];
            `PIO_SEL_DIR_B: rdata_nxt = dir_r[1];
            `PIO_SEL_DIR_C: rdata_nxt = dir_r[2];
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         cpu_rdata <= '0;
      else
         cpu_rdata <= rdata_nxt;
   end

   // read data path
   AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !cpu_rd |=> cpu_rdata == '0)
      else $error("read data not idle");
   AST_DIR_A_READ: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_rd && cpu_addr == `PIO_SEL_DIR_A |=> cpu_rdata == $past(first_bidir_port_pins_oe))
      else $error("port a direction readback mismatch");
   AST_DIR_B_READ: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_rd && cpu_addr == `PIO_SEL_DIR_B |=> cpu_rdata == $past(second_bidir_port_pins_oe))
      else $error("port b direction readback mismatch");
   AST_READ_B_MIX: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_rd && cpu_addr == `PIO_SEL_DATA_B |=> cpu_rdata ==
      (($past(second_bidir_port_pins_oe) & $past(second_bidir_port_pins_o)) |
      (~$past(second_bidir_port_pins_oe) & $past(second_bidir_port_pins_i))))
      else $error("port b read not pin or latch per direction");
   AST_READ_C_MIX: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_rd && cpu_addr == `PIO_SEL_DATA_C |=> cpu_rdata ==
      (($past(third_bidir_port_pins_oe) & $past(third_bidir_port_pins_o)) |
      (~$past(third_bidir_port_pins_oe) & $past(third_bidir_port_pins_i))))
      else $error("port c read not pin or latch per direction");
   AST_REFUSED_READ: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_rd && cpu_addr == `PIO_SEL_NONE |=> cpu_rdata == '0)
      else $error("unused address read not zero");
   AST_FIXED_SER_PINS: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_rd && cpu_addr == `PIO_SEL_DATA_D && !(serial_ctl.rx_en && serial_ctl.tx_en)
      |=> cpu_rdata[`PIO_BIT_TXD:`PIO_BIT_RXD] == $past(input_only_port_pins[1:0]))
      else $error("serial bits not pin levels");
   AST_FIXED_BIT7: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_rd && cpu_addr == `PIO_SEL_DATA_D |=> cpu_rdata[7] == $past(input_only_port_pins[7]))
      else $error("fixed port bit 7 not pin level");

   AST_DIR_RESET: assert property (@(posedge clk_sys)
      $rose(arst_n) |-> (first_bidir_port_pins_oe == '0
      && second_bidir_port_pins_oe == '0 && third_bidir_port_pins_oe == '0))
      else $error("direction not cleared by reset");
   AST_OE_FOLLOWS_DIR: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_wr && cpu_addr == `PIO_SEL_DIR_A |=> first_bidir_port_pins_oe == $past(cpu_wdata))
      else $error("oe not updated next cycle after direction write");
   AST_LATCH_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_wr && cpu_addr == `PIO_SEL_DATA_B |=> second_bidir_port_pins_o == $past(cpu_wdata))
      else $error("latch write lost");
   AST_DIR_READBACK: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_rd && cpu_addr == `PIO_SEL_DIR_C |=> cpu_rdata == $past(third_bidir_port_pins_oe))
      else $error("direction readback mismatch");
   AST_READ_MIX: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_rd && cpu_addr == `PIO_SEL_DATA_A |=> cpu_rdata ==
      (($past(first_bidir_port_pins_oe) & $past(first_bidir_port_pins_o)) |
      (~$past(first_bidir_port_pins_oe) & $past(first_bidir_port_pins_i))))
      else $error("port read not pin or latch per direction");
   AST_FIXED_BIT6: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_rd && cpu_addr == `PIO_SEL_DATA_D |=> cpu_rdata[6] == 1'b0)
      else $error("fixed port bit 6 not zero");
   AST_SER_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_rd && cpu_addr == `PIO_SEL_DATA_D && serial_ctl.rx_en && serial_ctl.tx_en
      |=> cpu_rdata[1:0] == 2'h0)
      else $error("serial bits not zero");
   AST_SPI_PINS: assert property (@(posedge clk_sys) disable iff (!arst_n)
      cpu_rd && cpu_addr == `PIO_SEL_DATA_D && !serial_ctl.spi_en
      |=> cpu_rdata[5:2] == $past(input_only_port_pins[5:2]))
      else $error("spi bits not pin levels");
   AST_NO_DRIVE_IDLE: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !serial_ctl.tx_en && !serial_ctl.spi_en |=> fixed_drive.oe == '0)
      else $error("fixed port driven with functions off");
endmodule // parallel_io_ports
`default_nettype wire

// ===== testbench/board_pins.sv
// pin model: board devices drive every line that the block leaves undriven
// assumes per-bit enables from the block, high while the block drives
`default_nettype none
module board_pins (
   input wire logic [7:0] drv_o,
   input wire logic [7:0] drv_oe,
   input wire logic [7:0] board,
   output logic [7:0] level
);
   timeunit 1ns;
   timeprecision 100ps;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         level[i] = drv_oe[i] ? drv_o[i] : board[i];
      end
   end
endmodule // board_pins
`default_nettype wire

// ===== testbench/parallel_io_ports_test.sv
// testbench for the parallel i/o block: register access, pins, fixed port
// assumes pio_cfg.svh on the include path and board_pins as the pin model
`include "pio_cfg.svh"
`default_nettype none
module parallel_io_ports_test;
   timeunit 1ns;
   timeprecision 100ps;
   import pio_pkg::*;
   logic clk_sys, arst_n, cpu_wr, cpu_rd, tx, mi_o, mi_oe, mo_o, mo_oe, sk_o, sk_oe;
   logic [2:0] cpu_addr;
   logic [7:0] cpu_wdata, lat, dir;
   wire [7:0] cpu_rdata;
   wire rx_in, miso_in, mosi_in, sck_in, ss_n_in;
   serial_ctl_t ctl;
   pin_drive_t fd;
   logic [3:0][7:0] brd;
   wire [3:0][7:0] o, oe, lvl;
   int err_total, num_checks;
   assign o[3] = fd.out;
   assign oe[3] = fd.oe;
   parallel_io_ports parallel_io_ports_i (.clk_sys(clk_sys), .arst_n(arst_n),
      .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .cpu_rdata(cpu_rdata), .first_bidir_port_pins_i(lvl[0]),
      .first_bidir_port_pins_o(o[0]), .first_bidir_port_pins_oe(oe[0]),
      .second_bidir_port_pins_i(lvl[1]), .second_bidir_port_pins_o(o[1]),
      .second_bidir_port_pins_oe(oe[1]), .third_bidir_port_pins_i(lvl[2]),
      .third_bidir_port_pins_o(o[2]), .third_bidir_port_pins_oe(oe[2]),
      .input_only_port_pins(lvl[3]), .serial_ctl(ctl), .serial_tx_data(tx),
      .spi_miso_out(mi_o), .spi_miso_oe(mi_oe), .spi_mosi_out(mo_o), .spi_mosi_oe(mo_oe),
      .spi_sck_out(sk_o), .spi_sck_oe(sk_oe), .serial_receive_input(rx_in),
      .spi_miso_in(miso_in), .spi_mosi_in(mosi_in), .spi_sck_in(sck_in),
      .spi_ss_n_in(ss_n_in), .fixed_drive(fd));
   for (genvar g = 0; g < 4; g++) begin : g_pin
      board_pins board_pins_i (.drv_o(o[g]), .drv_oe(oe[g]), .board(brd[g]),
         .level(lvl[g]));
   end
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic summarize;
      $display("mismatches %0d, checks %0d", err_total, num_checks);
      if (err_total == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #2 cpu_wr = 1'b1;
      cpu_addr = a;
      cpu_wdata = d;
      @(posedge clk_sys);
      #2 cpu_wr = 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      #2 cpu_rd = 1'b1;
      cpu_addr = a;
      @(posedge clk_sys);
      #2 cpu_rd = 1'b0;
      chk(cpu_rdata, exp);
   endtask
   initial begin
      repeat (3000) @(posedge clk_sys);
      err_total++;
      summarize();
   end
   initial begin
      {arst_n, cpu_wr, cpu_rd, tx, mi_o, mi_oe, mo_o, mo_oe, sk_o, sk_oe} = '0;
      cpu_addr = 3'h0;
      cpu_wdata = 8'h00;
      ctl = '0;
      brd = {4{8'h3c}};
      repeat (4) @(posedge clk_sys);
      #2 arst_n = 1'b1;
      chk(oe[0] | oe[1] | oe[2], 8'h00);
      chk(fd.oe, 8'h00);
      for (int p = 0; p < 3; p++) begin
         lat = 8'ha5;
         dir = 8'h0f;
         rd(3'(4 + p), `PIO_DIR_RST);
         wr(3'(p), lat);
         chk(oe[p], 8'h00);
         chk(o[p], lat);
         rd(3'(p), brd[p]);
         wr(3'(4 + p), dir);
         chk(oe[p], dir);
         chk(lvl[p], (dir & lat) | (~dir & brd[p]));
         rd(3'(p), (dir & lat) | (~dir & brd[p]));
         rd(3'(4 + p), dir);
         wr(3'(p), 8'h5a);
         chk(lvl[p], (dir & 8'h5a) | (~dir & brd[p]));
      end
      wr(3'h7, 8'hff);
      rd(3'h7, 8'h00);
      rd(`PIO_SEL_DIR_A, 8'h0f);
      brd[3] = 8'hff;
      rd(`PIO_SEL_DATA_D, 8'hbf);
      brd[3] = 8'h6d;
      rd(`PIO_SEL_DATA_D, 8'h2d);
      chk({3'h0, ss_n_in, sck_in, mosi_in, miso_in, rx_in}, 8'h17);
      ctl.rx_en = 1'b1;
      ctl.tx_en = 1'b1;
      tx = 1'b1;
      rd(`PIO_SEL_DATA_D, 8'h2c);
      chk(oe[3] & o[3], 8'h02);
      ctl.spi_en = 1'b1;
      {mi_oe, sk_o, sk_oe} = 3'h7;
      repeat (2) @(posedge clk_sys);
      #2 chk(oe[3], 8'h16);
      chk(oe[3] & o[3], 8'h12);
      rd(`PIO_SEL_DATA_D, 8'h38);
      arst_n = 1'b0;
      #1 chk(oe[0] | fd.oe, 8'h00);
      @(posedge clk_sys);
      #2 arst_n = 1'b1;
      rd(`PIO_SEL_DIR_A, 8'h00);
      summarize();
   end
endmodule // parallel_io_ports_test
`default_nettype wire
